// ==== hdl/shc_defs.vh ====
`ifndef SHC_DEFS_VH
`define SHC_DEFS_VH

// Register map; byte addresses on the Wishbone bus.
`define SHC_ADDR_HOLD_CTRL 4'h0
`define SHC_ADDR_MODULE_STOP 4'h4
`define SHC_ADDR_STATUS 4'h8

// Hold-control register fields.
`define SHC_EN_LSB 2
`define SHC_EN_MSB 7
`define SHC_FSEL_LSB 0
`define SHC_FSEL_MSB 1
`define SHC_HOLD_CTRL_RESET 8'h00
`define SHC_MODULE_STOP_RESET 1'b0

// Hold delay in system clock cycles: the lower bound of each span.
`define SHC_HOLD_BASE 5'h02
`define SHC_HOLD_FS0 5'h03
`define SHC_HOLD_FS1 5'h04
`define SHC_HOLD_FS2 5'h06
`define SHC_HOLD_FS3 5'h0A

`define SHC_NCH 6

`endif

// ==== hdl/shc_hold_ctrl.v ====
// Functional notes
// (RULE1) Register bits 7..2 enable extended hold timing for channels 5..0, one bit each.
// (RULE2) Register bits 1..0 form a reset-zero frequency select that scales the extended hold.
// (RULE3) The hold-control register is readable and writable only while the module-stop bit is 0.
// (RULE4) Hold is 2 cycles when disabled, else 3, 4, 6 or 10 cycles for select 00, 01, 10, 11.
// (RULE5) Software picks enable and select by system clock range.
// (RULE6) Software must not pick a combination whose hold time leaves the SMBus range.
// (RULE7) Software should aim for a data hold between 300 ns and 1000 ns.
// (RULE8) Without SMBus needs, software leaves all bits at zero.
// (RULE9) Each channel counts system clocks from the clock-line fall and delays data changes.
`timescale 1ns/1ps
`include "shc_defs.vh"

module shc_hold_ctrl (
    // System.
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // Channel clock lines and raw data outputs from the channel engines.
    input wire [5:0] scl_i,
    input wire [5:0] sda_raw_i,
    // Held data-line outputs.
    output reg [5:0] sda_o
);

    reg [7:0] smbus_hold_control;
    reg module_stop_bit;
    reg [5:0] scl_m;
    reg [5:0] scl_s;
    reg [5:0] scl_d;
    reg [5:0] sda_m;
    reg [5:0] sda_s;
    reg [29:0] cnt;
    reg [5:0] busy;
    reg [31:0] next_dat;
    reg next_err;
    wire req;
    wire [5:0] hold_ext_en_chan;
    wire [1:0] fsel;
    integer i;

    assign hold_ext_en_chan = smbus_hold_control[`SHC_EN_MSB:`SHC_EN_LSB]; // [RULE1]
    assign fsel = smbus_hold_control[`SHC_FSEL_MSB:`SHC_FSEL_LSB]; // [RULE2]
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

    // Returns the hold count for one channel from its enable and the shared select.
    function [4:0] hold_len;
        input en;
        input [1:0] fs;
        begin
            if (!en) begin
                hold_len = `SHC_HOLD_BASE; // [RULE4]
            end else begin
                case (fs)
                    2'h0: hold_len = `SHC_HOLD_FS0; // [RULE4]
                    2'h1: hold_len = `SHC_HOLD_FS1;
                    2'h2: hold_len = `SHC_HOLD_FS2;
                    default: hold_len = `SHC_HOLD_FS3;
                endcase
            end
        end
    endfunction

    // Combinational read mux and error decode.
    always @* begin
        next_dat = 32'h00000000;
        next_err = 1'b0;
        case (wb_adr_i)
            `SHC_ADDR_HOLD_CTRL: begin
                if (module_stop_bit) begin
                    next_err = 1'b1; // [RULE3]
                end else begin
                    next_dat = {24'h000000, smbus_hold_control};
                end
            end
            `SHC_ADDR_MODULE_STOP: next_dat = {31'h0000000, module_stop_bit};
            `SHC_ADDR_STATUS: next_dat = {26'h000000, busy};
            default: next_err = 1'b1;
        endcase
    end

    // Bus slave: one wait-free cycle, ack or err in the cycle after the request.
    always @(posedge clk_i) begin
        if (rst_i) begin
            smbus_hold_control <= `SHC_HOLD_CTRL_RESET;
            module_stop_bit <= `SHC_MODULE_STOP_RESET;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~next_err;
            wb_err_o <= req & next_err;
            if (req) begin
                wb_dat_o <= wb_we_i ? 32'h00000000 : next_dat;
            end
            // A write lands at the edge at which the master samples ack high.
            if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == `SHC_ADDR_HOLD_CTRL) begin
                    smbus_hold_control <= wb_dat_i[7:0]; // [RULE3]
                end
                if (wb_adr_i == `SHC_ADDR_MODULE_STOP) begin
                    module_stop_bit <= wb_dat_i[0];
                end
            end
        end
    end

    // Pin synchronisers and per-channel hold counters.
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_m <= 6'h3F;
            scl_s <= 6'h3F;
            scl_d <= 6'h3F;
            sda_m <= 6'h3F;
            sda_s <= 6'h3F;
            cnt <= 30'h0000000;
            busy <= 6'h00;
            sda_o <= 6'h3F;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_raw_i;
            sda_s <= sda_m;
            for (i = 0; i < `SHC_NCH; i = i + 1) begin
                if (scl_d[i] && !scl_s[i]) begin
                    busy[i] <= 1'b1; // [RULE9]
                    cnt[i*5 +: 5] <= hold_len(hold_ext_en_chan[i], fsel) - 5'h01;
                end else if (busy[i]) begin
                    if (cnt[i*5 +: 5] == 5'h00) begin
                        busy[i] <= 1'b0;
                        sda_o[i] <= sda_s[i]; // [RULE9]
                    end else begin
                        cnt[i*5 +: 5] <= cnt[i*5 +: 5] - 5'h01;
                    end
                end else begin
                    sda_o[i] <= sda_s[i];
                end
            end
        end
    end

endmodule // shc_hold_ctrl

// ==== tb/shc_hold_ctrl_bench.sv ====
`timescale 1ns/1ps
module shc_hold_ctrl_bench;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wb_err_o;
    wire [5:0] scl_i, sda_raw_i, sda_o;
    logic [9:0] q[$];
    logic [9:0] e;
    logic [7:0] v;
    int failures = 0, n_compared = 0, cnt = 0;
    int h;
    int hold[5] = '{2, 3, 4, 6, 10};
    initial forever #2 clk_i = ~clk_i;
    shc_link_partner u_far (.scl_o(scl_i), .sda_o(sda_raw_i));
    shc_hold_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .scl_i(scl_i),
        .sda_raw_i(sda_raw_i), .sda_o(sda_o));
    task chk(input logic [8:0] s, input logic [8:0] x);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, s, x);
        end
    endtask
    task stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wb(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [8:0] x);
        q.push_back({w, x});
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk_i); while (!(wb_ack_o | wb_err_o));
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o | wb_err_o) begin
            e = q.pop_front();
            chk({wb_err_o, e[9] ? e[7:0] : wb_dat_o[7:0]}, e[8:0]);
        end
    end
    always @(posedge clk_i) if (++cnt == 5000) begin
        failures++;
        stop_test;
    end
    initial begin
        v = $urandom(32'h259880e7);
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(4'h0, 0, 0, 9'h000);
        v = $urandom;
        wb(4'h0, 1, v, 9'h000);
        wb(4'h0, 0, 0, {1'b0, v});
        wb(4'h4, 1, 8'h01, 9'h000);
        wb(4'h4, 0, 0, 9'h001);
        wb(4'h0, 1, ~v, 9'h100);
        wb(4'h0, 0, 0, 9'h100);
        wb(4'h4, 1, 8'h00, 9'h000);
        wb(4'h0, 0, 0, {1'b0, v});
        wb(4'hC, 0, 0, 9'h100);
        for (int k = 0; k < 5; k++) begin
            v = k == 0 ? 8'h00 : {6'h01, 2'(k - 1)};
            wb(4'h0, 1, v, 9'h000);
            repeat (3) begin
                @(negedge scl_i[0]);
                @(posedge clk_i);
                h = 0;
                do begin
                    @(negedge clk_i);
                    h++;
                end while (sda_o[0] !== sda_raw_i[0] && h < 40);
                chk(9'(h), 9'(hold[k] + 3));
                chk({3'h0, sda_o}, {3'h0, sda_raw_i});
                @(posedge clk_i);
                wb(4'h8, 0, 0, 9'h000);
            end
        end
        stop_test;
    end
endmodule // shc_hold_ctrl_bench

// ==== tb/shc_hold_ctrl_sva.sv ====
`timescale 1ns/1ps
module shc_hold_ctrl_sva (
    input wire clk_i, input wire rst_i, input wire wb_cyc_i, input wire wb_stb_i,
    input wire [3:0] wb_adr_i, input wire wb_ack_o, input wire wb_err_o,
    input wire [5:0] scl_i, input wire [5:0] sda_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    a_req_answer: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("no reply");
    a_unmapped_err: assert property (req && wb_adr_i == 4'hC |=> wb_err_o)
        else $error("no err");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_hold_freeze: assert property ($fell(scl_i[0]) |-> ##3 $stable(sda_o[0]) ##1 $stable(sda_o[0]))
        else $error("short hold");
    a_reset_idle: assert property ($fell(rst_i) |-> sda_o == 6'h3F)
        else $error("sda not idle");
    c_err: cover property (wb_err_o);
    c_read: cover property (wb_ack_o && wb_adr_i == 4'h0);
    c_fall: cover property ($fell(scl_i[0]));
endmodule // shc_hold_ctrl_sva
bind shc_hold_ctrl shc_hold_ctrl_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
    .wb_ack_o, .wb_err_o, .scl_i, .sda_o);

// ==== tb/shc_link_partner.sv ====
`timescale 1ns/1ps
module shc_link_partner (
    // Link lines.
    output logic [5:0] scl_o,
    output logic [5:0] sda_o
);
    // Raw data changes together with the clock-line fall, so only the hold keeps it back.
    initial begin
        scl_o = 6'h3F;
        sda_o = 6'h3F;
        #103;
        forever begin
            #40 scl_o = 6'h00;
            sda_o = sda_o + 6'h2B;
            #40 scl_o = 6'h3F;
        end
    end
endmodule // shc_link_partner
